// ==== dv/pfs_monitor.sv ====
`timescale 1ns/1ps
module pfs_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        dc_power_good,
  input wire logic        power_reserve_good,
  input wire logic        bus_initialize_n,
  input wire logic        powerup_start,
  input wire logic        pfail_trap,
  input wire logic [15:0] trap_vector
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_init_hold: assert property ($fell(bus_initialize_n) |-> !$past(dc_power_good)) else $error("init low");
  a_init_free: assert property ($rose(bus_initialize_n) |-> $past(dc_power_good)) else $error("init free");
  a_up_cause: assert property (powerup_start |-> $past(power_reserve_good)) else $error("start");
  a_trap_vector: assert property (pfail_trap |=> trap_vector == pfs_pkg::PFAIL_VECTOR) else $error("vector");
  a_no_restart: assert property (pfail_trap |=> !powerup_start [*8]) else $error("restart");
endmodule
bind pfs_sequencer pfs_monitor pfs_monitor_inst (.*);

// ==== dv/pfs_supply.sv ====
`timescale 1ns/1ps
module pfs_supply #(parameter int GAP = 70) (
  input wire logic clk,
  input wire logic on,
  output logic     dc_power_good,
  output logic     power_reserve_good
);
  int n_q = 0; // dc outlives reserve, so power-fail has time
  always @(posedge clk) n_q <= on ? (n_q < GAP ? n_q + 1 : GAP) : (n_q > 0 ? n_q - 1 : 0);
  assign dc_power_good = n_q > 0;
  assign power_reserve_good = on && n_q >= GAP;
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic        clk = 0, rst_n = 0, on = 0, instr_done = 0, halt_done = 0, other_master_busy = 0;
  logic        dc_power_good, power_reserve_good, bus_initialize_n, powerup_start, pfail_trap;
  logic        cpu_enable, pfail_overrun, release_overrun;
  logic [15:0] trap_vector;
  int          n_fail = 0, comparisons = 0;
  pfs_supply pfs_supply_inst (.*);
  pfs_sequencer #(.PFAIL_CYC(50), .RELEASE_CYC(20)) pfs_sequencer_inst (.*);
  initial forever #5 clk = ~clk;
  task automatic check(string s, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic await(ref logic g, input logic e, input string s);
    for (int i = 0; i < 300 && g !== e; i++) @(posedge clk) #1;
    check(s, e, g);
    if (g !== e) conclude();
  endtask
  task automatic t_powerup();
    check("init", 16'h0, bus_initialize_n);
    on = 1;
    await(bus_initialize_n, 1'b1, "free");
    await(powerup_start, 1'b1, "start");
    @(posedge clk) #1;
    check("cpu_enable", 16'h1, cpu_enable);
    $display("end powerup");
  endtask
  task automatic t_pfail(logic busy, logic halt);
    other_master_busy = busy;
    on = 0;
    instr_done = 1;
    await(pfail_trap, 1'b1, "trap");
    halt_done = halt;
    on = halt;
    #600;
    check("vector", 16'h0018, trap_vector);
    check("release", busy, release_overrun);
    check("budget", !halt, pfail_overrun);
    check("cpu_enable", 16'h0, cpu_enable);
    on = 0;
    await(bus_initialize_n, 1'b0, "reinit");
    $display("end pfail");
  endtask
  initial begin
    #76 rst_n = 1;
    t_powerup();
    t_pfail(1'b0, 1'b1);
    t_powerup();
    t_pfail(1'b1, 1'b0);
    conclude();
  end
endmodule

// ==== logic/pfs_pkg.sv ====
// Operation
// - while dc power is not good the processor holds the bus initialize line asserted, except in a power-down before its power-fail timer expires.
// - once power reserve good is asserted the processor runs its power-up sequence.
// - on power reserve good negation the processor finishes its instruction and traps through vector 16'h0018 (24 decimal).
// - a started power-down runs to completion before a new power-up begins, except that dc loss after its power-fail timer expires aborts it to PFS_OFF.
package pfs_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned PFAIL_BUDGET_MS  = 4;
  localparam int unsigned PFAIL_BUDGET_CYC = PFAIL_BUDGET_MS * 1000 * CLK_MHZ;
  localparam int unsigned MASTER_REL_MS    = 1;
  localparam int unsigned MASTER_REL_CYC   = MASTER_REL_MS * 1000 * CLK_MHZ;
  localparam logic [15:0] PFAIL_VECTOR     = 16'h0018; // 24 decimal, 30 octal
  localparam logic [15:0] BOOT_VECTOR_RST  = 16'h0000;

  typedef enum logic [2:0] {
    PFS_OFF      = 3'b000,
    PFS_WAIT_PWR = 3'b001,
    PFS_POWERUP  = 3'b010,
    PFS_RUN      = 3'b011,
    PFS_PF_DRAIN = 3'b100,
    PFS_PF_TRAP  = 3'b101,
    PFS_PF_WAIT  = 3'b110,
    PFS_DOWN     = 3'b111
  } pfs_state_e;
endpackage

// ==== logic/pfs_sequencer.sv ====
`timescale 1ns/1ps
module pfs_sequencer #(
  parameter int unsigned PFAIL_CYC  = pfs_pkg::PFAIL_BUDGET_CYC,
  parameter int unsigned RELEASE_CYC = pfs_pkg::MASTER_REL_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        dc_power_good,
  input  wire logic        power_reserve_good,
  input  wire logic        instr_done,
  input  wire logic        halt_done,
  input  wire logic        other_master_busy,
  output logic             bus_initialize_n,
  output logic             powerup_start,
  output logic             pfail_trap,
  output logic [15:0]      trap_vector,
  output logic             cpu_enable,
  output logic             pfail_overrun,
  output logic             release_overrun
);
  pfs_pkg::pfs_state_e state_q, state_d;
  logic        pok_q;
  logic        init_q;
  logic        pup_q;
  logic        trap_q;
  logic [15:0] vec_q;
  logic        ovr_q;
  logic        rel_ovr_q;
  logic        pf_run;
  logic        pf_exp;
  logic        rel_run;
  logic        rel_exp;

  wire pok_fall   = pok_q && !power_reserve_good;
  wire pf_start   = (state_q == pfs_pkg::PFS_RUN) && !power_reserve_good;
  wire in_pfail   = (state_q == pfs_pkg::PFS_PF_DRAIN) || (state_q == pfs_pkg::PFS_PF_TRAP)
                    || (state_q == pfs_pkg::PFS_PF_WAIT);

  always_comb begin
    state_d = state_q;
    case (state_q)
      pfs_pkg::PFS_OFF:      if (dc_power_good) state_d = pfs_pkg::PFS_WAIT_PWR;
      pfs_pkg::PFS_WAIT_PWR: begin
        if (!dc_power_good) state_d = pfs_pkg::PFS_OFF;
        else if (power_reserve_good) state_d = pfs_pkg::PFS_POWERUP;
      end
      pfs_pkg::PFS_POWERUP:  state_d = pfs_pkg::PFS_RUN;
      pfs_pkg::PFS_RUN:      begin
        if (!dc_power_good) state_d = pfs_pkg::PFS_OFF;
        else if (!power_reserve_good) state_d = pfs_pkg::PFS_PF_DRAIN;
      end
      pfs_pkg::PFS_PF_DRAIN: if (instr_done) state_d = pfs_pkg::PFS_PF_TRAP;
      pfs_pkg::PFS_PF_TRAP:  state_d = pfs_pkg::PFS_PF_WAIT;
      pfs_pkg::PFS_PF_WAIT:  if (halt_done || pf_exp) state_d = pfs_pkg::PFS_DOWN;
      pfs_pkg::PFS_DOWN:     if (!dc_power_good) state_d = pfs_pkg::PFS_OFF;
      default:               state_d = pfs_pkg::PFS_OFF;
    endcase
    // power-down finishes first; dc loss only aborts it once the power-fail timer has expired
    if (in_pfail && !dc_power_good && pf_exp) state_d = pfs_pkg::PFS_OFF;
  end

  pfs_timer #(.W(32)) u_pf_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (pf_start),
    .limit   (PFAIL_CYC),
    .running (pf_run),
    .expired (pf_exp)
  );

  pfs_timer #(.W(32)) u_rel_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (pok_fall),
    .limit   (RELEASE_CYC),
    .running (rel_run),
    .expired (rel_exp)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= pfs_pkg::PFS_OFF;
      pok_q     <= 1'b0;
      init_q    <= 1'b1;
      pup_q     <= 1'b0;
      trap_q    <= 1'b0;
      vec_q     <= pfs_pkg::BOOT_VECTOR_RST;
      ovr_q     <= 1'b0;
      rel_ovr_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      pok_q     <= power_reserve_good;
      init_q    <= (state_d == pfs_pkg::PFS_OFF);
      pup_q     <= (state_d == pfs_pkg::PFS_POWERUP);
      trap_q    <= (state_d == pfs_pkg::PFS_PF_TRAP);
      if (state_d == pfs_pkg::PFS_PF_TRAP) vec_q <= pfs_pkg::PFAIL_VECTOR;
      // sticky until next power-up; set wins over clear
      if (pf_exp && (state_q == pfs_pkg::PFS_PF_WAIT) && !halt_done) ovr_q <= 1'b1;
      else if (state_d == pfs_pkg::PFS_POWERUP) ovr_q <= 1'b0;
      // watches the far side only; diagnostic
      if (rel_run && other_master_busy && rel_exp) rel_ovr_q <= 1'b1;
      else if (rel_exp && other_master_busy) rel_ovr_q <= 1'b1;
      else if (state_d == pfs_pkg::PFS_POWERUP) rel_ovr_q <= 1'b0;
    end
  end

  assign bus_initialize_n = !init_q;
  assign powerup_start    = pup_q;
  assign pfail_trap       = trap_q;
  assign trap_vector      = vec_q;
  assign cpu_enable       = (state_q == pfs_pkg::PFS_RUN) || (state_q == pfs_pkg::PFS_PF_DRAIN)
                            || (state_q == pfs_pkg::PFS_PF_WAIT) || (state_q == pfs_pkg::PFS_PF_TRAP);
  assign pfail_overrun    = ovr_q;
  assign release_overrun  = rel_ovr_q;
endmodule

// ==== logic/pfs_timer.sv ====
`timescale 1ns/1ps
module pfs_timer #(
  parameter int unsigned W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] limit,
  output logic              running,
  output logic              expired
);
  logic [W-1:0] cnt_q;
  logic         run_q;
  logic         exp_q;
  wire          hit = run_q && (cnt_q >= limit);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else if (start) begin
      cnt_q <= {{(W-1){1'b0}}, 1'b1};
      run_q <= 1'b1;
      exp_q <= 1'b0;
    end else if (hit) begin
      run_q <= 1'b0;
      exp_q <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign running = run_q;
  assign expired = exp_q;
endmodule
